// File: shared/tx_pcf_pkg.sv
// shared constants and carrier types for the transmit phase compensation buffer
package tx_pcf_pkg;
  // =====================================================================
  // geometry
  localparam int DEPTH = 4;
  localparam int ADDR_W = 2;
  localparam int PTR_W = 3;
  localparam int DATA_MAX_W = 20;
  localparam int BYTE_W = 8;
  localparam int SYMBOL_W = 10;
  localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
  localparam logic SRC_FABRIC = 1'b0;
  localparam logic SRC_PIPE = 1'b1;

  // =====================================================================
  // one transmit word with its qualifier
  typedef struct packed {
    logic valid;
    logic [DATA_MAX_W-1:0] data;
  } tx_word_t;

  localparam tx_word_t WORD_RST = '{valid: 1'b0, data: 20'h0_0000};
endpackage

// File: testbench/tb_tx_phase_comp_fifo.sv
// self-checking bench for the transmit phase compensation buffer
`timescale 1ns/1ps
module tb_tx_phase_comp_fifo;
  import tx_pcf_pkg::*;
  logic i_sys_clk = 0, i_rst_b = 0, wr = 0, rd = 0, ld = 0, sel = 0, flip = 0, rm = 0, ready;
  logic [15:0] s = 16'h0057;
  logic [19:0] q[$];
  tx_word_t fab, out;
  int fail_count = 0, checks_done = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  tx_pcf_src u_src (.i_load(ld), .i_data({s[3:0], s}), .o_word(fab));
  tx_phase_comp_fifo u_dut (.i_sys_clk, .i_rst_b, .i_wr_ce(wr), .i_rd_ce(rd), .i_src_sel(sel), .i_fab_word(fab),
    .i_pipe_word({fab.valid, ~fab.data}), .i_bit_flip(flip), .i_registered_mode(rm), .o_wr_ready(ready),
    .o_tx_word(out));
  function automatic logic [15:0] lf(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // expected stored word: pick the source, then reverse each 10-bit symbol when flip is set
  function automatic logic [19:0] ex(logic [19:0] d);
    logic [19:0] v;
    v = sel ? ~d : d;
    ex = v;
    for (int i = 0; i < 20; i++) if (flip) ex[i] = v[i / 10 * 10 + 9 - i % 10];
  endfunction
  task chk(string n, logic [19:0] e, logic [19:0] g);
    checks_done++;
    fail_count += int'(g !== e);
    if (g !== e) $display("CHECK FAILED %s exp %h got %h", n, e, g);
  endtask
  // one cycle: drive at the falling edge, log takes before the rise, check after
  task step(logic w, logic r, logic l);
    @(negedge i_sys_clk);
    {wr, rd, ld} = {w, r, l};
    s = lf(s);
    #12;
    if (wr && ready && fab.valid) q.push_back(ex(fab.data));
    @(posedge i_sys_clk);
    #1;
    if (rd && out.valid) chk("word", q.size() ? q.pop_front() : 'x, out.data);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // every source, flip and mode mix: fill, lone word, then random traffic
  initial
  begin
    repeat (10) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_b = 1;
    for (int m = 0; m < 8; m++)
    begin
      repeat (12) step(1, 1, 0);
      @(negedge i_sys_clk);
      {sel, flip, rm} = 3'(m);
      repeat (4) step(1, 0, 1);
      chk("ready", 0, 20'(ready));
      repeat (12) step(1, 1, 0);
      step(1, 1, 1);
      repeat (3) step(1, 1, 0);
      repeat (60) step(s[0] | s[1], s[2] | s[3], s[4] | s[5]);
      $display("test %0d done", m);
    end
    repeat (12) step(1, 1, 0);
    chk("left", 0, 20'(q.size()));
    give_verdict;
  end
endmodule
bind tx_phase_comp_fifo tx_pcf_props u_props (.i_sys_clk, .i_rst_b, .i_wr_ce, .i_rd_ce, .i_src_sel, .i_fab_word,
  .i_pipe_word, .i_bit_flip, .i_registered_mode, .o_wr_ready, .o_tx_word);

// File: testbench/tx_pcf_props.sv
// assertion checker for the transmit phase compensation buffer
`timescale 1ns/1ps
module tx_pcf_props
  import tx_pcf_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_ce,
  input wire logic i_rd_ce,
  input wire logic i_src_sel,
  input wire tx_word_t i_fab_word,
  input wire tx_word_t i_pipe_word,
  input wire logic i_bit_flip,
  input wire logic i_registered_mode,
  input wire logic o_wr_ready,
  input wire tx_word_t o_tx_word
);
  logic tk;
  logic rm;
  // a write counts only with room and a valid picked word
  assign tk = i_wr_ce && o_wr_ready && (i_src_sel ? i_pipe_word.valid : i_fab_word.valid);
  assign rm = i_registered_mode;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  a_reset_empty: assert property ($rose(i_rst_b) |-> o_wr_ready && !o_tx_word.valid) else $error("dirty");
  a_hold_idle: assert property (!i_rd_ce |=> $stable(o_tx_word)) else $error("moved");
  a_reg_latency: assert property (rm && tk ##1 i_rd_ce |=> o_tx_word.valid) else $error("reg late");
  a_reg_single: assert property ((rm && !tk && i_rd_ce)[*8] ##1 tk ##1 (i_rd_ce && !tk)[*2]
    |=> !o_tx_word.valid) else $error("reg twice");
  a_norm_latency: assert property (!rm && tk ##1 i_rd_ce[*3] |=> o_tx_word.valid) else $error("late");
  a_norm_early: assert property ((!rm && !tk && i_rd_ce)[*8] ##1 tk |=> !o_tx_word.valid[*2]) else $error("early");
  a_full_depth: assert property ((tk && !i_rd_ce)[*4] |=> !o_wr_ready) else $error("deep");
  a_drain_idle: assert property ((!tk && i_rd_ce)[*8] |=> !o_tx_word.valid) else $error("ghost");
endmodule

// File: testbench/tx_pcf_src.sv
// fabric source model offering transmit words
`timescale 1ns/1ps
module tx_pcf_src
  import tx_pcf_pkg::*;
(
  input wire logic i_load,
  input wire logic [19:0] i_data,
  output tx_word_t o_word
);
  // an unoffered slot carries inverted bits so stale data never looks valid
  assign o_word = '{valid: i_load, data: i_load ? i_data : ~i_data};
endmodule

// File: verilog/tx_pcf_gray_sync.sv
// two-stage pointer synchroniser advanced by a clock enable
`timescale 1ns/1ps
module tx_pcf_gray_sync
  import tx_pcf_pkg::*;
#(
  parameter int W = PTR_W
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [W-1:0] i_gray,
  output logic [W-1:0] o_gray
);
  logic [W-1:0] stage1;

  // =====================================================================
  // first stage feeds only the second; gray code keeps a skewed capture one step off at most
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      stage1 <= '0;
      o_gray <= '0;
    end
    else if (i_ce)
    begin
      stage1 <= i_gray;
      o_gray <= stage1;
    end
  end
endmodule

// File: verilog/tx_phase_comp_fifo.sv
// transmit phase compensation buffer between fabric write rate and parallel read rate
`timescale 1ns/1ps
module tx_phase_comp_fifo
  import tx_pcf_pkg::*;
#(
  parameter int DATA_W = 20
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_ce,
  input wire logic i_rd_ce,
  input wire logic i_src_sel,
  input wire tx_word_t i_fab_word,
  input wire tx_word_t i_pipe_word,
  input wire logic i_bit_flip,
  input wire logic i_registered_mode,
  output logic o_wr_ready,
  output tx_word_t o_tx_word
);
  // =====================================================================
  // elaboration checks
  // the four legal widths are one or two bytes, or one or two ten-bit symbols
  localparam int WIDE_BYTE_W = BYTE_W + BYTE_W;
  localparam int WIDE_SYMBOL_W = SYMBOL_W + SYMBOL_W;
  localparam bit WIDTH_OK = (DATA_W == BYTE_W) || (DATA_W == SYMBOL_W) ||
    (DATA_W == WIDE_BYTE_W) || (DATA_W == WIDE_SYMBOL_W);
  // pointers carry one lap bit above the address so full and empty differ
  localparam bit GEOMETRY_OK = (DEPTH == (1 << ADDR_W)) && (PTR_W == ADDR_W + 1);

  // refuse widths the output carrier or the flip grouping cannot serve
  generate
    if (!WIDTH_OK)
    begin : g_bad_width
      $error("DATA_W must be 8, 10, 16 or 20");
    end
    if (!GEOMETRY_OK)
    begin : g_bad_geometry
      $error("pointer width does not match the four word store");
    end
    if (DATA_W > DATA_MAX_W)
    begin : g_too_wide
      $error("DATA_W exceeds the carrier width");
    end
  endgenerate

  // flip group: bytes for 8/16, ten-bit symbols for 10/20
  // a ten-bit symbol is flipped whole, since splitting it would scatter code bits
  localparam int GRP_W = (DATA_W % BYTE_W == 0) ? BYTE_W : SYMBOL_W;
  // one pointer step per accepted word or per read
  localparam logic [PTR_W-1:0] PTR_STEP = 3'h1;
  // binary to gray is a single right shift and exclusive or
  localparam int GRAY_SHIFT = 1;

  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_bin;
  logic [PTR_W-1:0] rd_bin;
  logic [PTR_W-1:0] wr_gray;
  logic [PTR_W-1:0] rd_gray;
  logic [PTR_W-1:0] wr_gray_at_rd;
  logic [PTR_W-1:0] rd_gray_at_wr;
  logic [PTR_W-1:0] next_wr_bin;
  logic [PTR_W-1:0] next_rd_bin;
  logic [PTR_W-1:0] wr_seen;
  tx_word_t src_word;
  logic [DATA_W-1:0] flipped;
  logic [DATA_W-1:0] in_data;
  logic full;
  logic empty;
  logic do_write;
  logic do_read;

  // =====================================================================
  // source selection
  assign src_word = (i_src_sel == SRC_PIPE) ? i_pipe_word : i_fab_word;

  // =====================================================================
  // bit flip within each group, one generate entry per bit
  genvar b;
  generate
    for (b = 0; b < DATA_W; b++)
    begin : g_flip
      localparam int GBASE = (b / GRP_W) * GRP_W;
      localparam int GOFS = b % GRP_W;
      assign flipped[b] = src_word.data[GBASE + GRP_W - 1 - GOFS];
    end
  endgenerate

  assign in_data = i_bit_flip ? flipped : src_word.data[DATA_W-1:0];

  // =====================================================================
  // pointer arithmetic and flags
  // pointers wrap naturally at the lap bit, so no compare is needed
  assign next_wr_bin = wr_bin + PTR_STEP;
  assign next_rd_bin = rd_bin + PTR_STEP;
  // only one gray bit moves per step, so a capture mid-change is one step stale at most
  assign wr_gray = wr_bin ^ (wr_bin >> GRAY_SHIFT);
  assign rd_gray = rd_bin ^ (rd_bin >> GRAY_SHIFT);
  // full when the write pointer sits one lap ahead of the seen read pointer
  assign full = (wr_gray == {~rd_gray_at_wr[PTR_W-1:PTR_W-2], rd_gray_at_wr[PTR_W-3:0]});
  // registered mode skips the synchroniser for single-cycle latency
  assign wr_seen = i_registered_mode ? wr_gray : wr_gray_at_rd;
  assign empty = (rd_gray == wr_seen);
  assign o_wr_ready = !full;
  assign do_write = i_wr_ce && src_word.valid && !full;
  assign do_read = i_rd_ce && !empty;

  // =====================================================================
  // crossings of each pointer into the other side's rate
  // both rates share one clock, so each stage advances only on its side's enable;
  // this models the real phase offset as a count of enable pulses, not of edges.
  // the write side sees reads late, so full clears a few write slots after a read:
  // the store never overruns, at the price of refusing a word it could have held.
  // the read side sees writes late by two read slots, which sets the normal latency.
  // registered mode bypasses this stage; it is only safe while both rates agree,
  // and the mode may only change while the store is empty.
  tx_pcf_gray_sync #(.W(PTR_W)) u_wr_to_rd
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_rd_ce),
    .i_gray(wr_gray),
    .o_gray(wr_gray_at_rd)
  );

  tx_pcf_gray_sync #(.W(PTR_W)) u_rd_to_wr
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_wr_ce),
    .i_gray(rd_gray),
    .o_gray(rd_gray_at_wr)
  );

  // =====================================================================
  // write side: storage, no reset needed since empty masks stale words
  always_ff @(posedge i_sys_clk)
  begin
    if (do_write)
    begin
      mem[wr_bin[ADDR_W-1:0]] <= in_data;
    end
  end

  // write pointer, cleared by reset so the buffer starts empty
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_bin <= PTR_RST;
    end
    else if (do_write)
    begin
      wr_bin <= next_wr_bin;
    end
  end

  // =====================================================================
  // read side: pointer
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rd_bin <= PTR_RST;
    end
    else if (do_read)
    begin
      rd_bin <= next_rd_bin;
    end
  end

  // output word register, refreshed each parallel cycle; valid drops on underrun
  // data holds its last word on underrun so the coder downstream sees no glitch;
  // bits above the configured width stay zero so narrow channels read cleanly
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_tx_word <= WORD_RST;
    end
    else if (i_rd_ce)
    begin
      o_tx_word.valid <= !empty;
      if (!empty)
      begin
        o_tx_word.data <= '0;
        o_tx_word.data[DATA_W-1:0] <= mem[rd_bin[ADDR_W-1:0]];
      end
    end
  end
endmodule
